/* amfs_consts.vh */
`ifndef AMFS_CONSTS_VH
`define AMFS_CONSTS_VH
// register indexes; the byte address on the bus is four times the index
`define AMFS_IDX_SLOT10 16'h2100
`define AMFS_IDX_SLOT89 16'h2101
`define AMFS_IDX_SLOT67 16'h2102
`define AMFS_IDX_SLOT45 16'h2103
`define AMFS_IDX_SLOT23 16'h2104
`define AMFS_IDX_SLOT01 16'h2105
`define AMFS_IDX_EQCHOP 16'h2106
`define AMFS_IDX_FILT 16'h210c
`define AMFS_IDX_RATE 16'h2200
`define AMFS_IDX_PREAMP 16'h2704
`define AMFS_IDX_REMOTE 16'h2709
`define AMFS_IDX_STATUS 16'h2800
`define AMFS_REG_RESET 8'h00
`define AMFS_SLOT_COUNT_LSB 4
`define AMFS_CHOP_LSB 2
`define AMFS_FIR_LEN_LSB 1
`define AMFS_ADC_DIV_BIT 5
`define AMFS_PLL_FAST_BIT 4
`define AMFS_RMT_LSB 3
`define AMFS_MAX_SLOTS 4'hb
`define AMFS_MAX_HANDLE 4'ha
`define AMFS_TICK_HZ 32768
`define AMFS_HCLK_HZ 100000000
`define AMFS_TICK_HALF_CYC ((`AMFS_HCLK_HZ / `AMFS_TICK_HZ) / 2)
`endif

/* amfs_tick_gen.v */
`include "amfs_consts.vh"
module amfs_tick_gen (
  hclk,
  hresetn,
  tick_rise
);
  input wire hclk;
  input wire hresetn;
  output reg tick_rise;
  reg [11:0] cnt_q;
  reg level_q;
  wire [31:0] half_last = `AMFS_TICK_HALF_CYC - 1;
  // slow tick derived from hclk; rise pulse marks each rising edge of the tick level
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 12'h000;
      level_q <= 1'b0;
      tick_rise <= 1'b0;
    end else begin
      tick_rise <= 1'b0;
      if (cnt_q == half_last[11:0]) begin
        cnt_q <= 12'h000;
        level_q <= ~level_q;
        tick_rise <= ~level_q;
      end else begin
        cnt_q <= cnt_q + 12'h001;
      end
    end
  end
endmodule // amfs_tick_gen

/* amfs_slot_timer.v */
module amfs_slot_timer (
  hclk,
  hresetn,
  tick_rise,
  restart,
  slot_len,
  slot_done
);
  input wire hclk;
  input wire hresetn;
  input wire tick_rise;
  input wire restart;
  input wire [4:0] slot_len;
  output wire slot_done;
  reg [4:0] cnt_q;
  // counts slow ticks; done on the tick that ends the slot
  assign slot_done = tick_rise && (cnt_q + 5'h01 >= slot_len);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 5'h00;
    end else if (restart) begin
      cnt_q <= 5'h00;
    end else if (tick_rise) begin
      cnt_q <= slot_done ? 5'h00 : cnt_q + 5'h01;
    end
  end
endmodule // amfs_slot_timer

/* amfs_frame_sequencer.v */
// Register access over AHB-Lite was chosen for this implementation.
`include "amfs_consts.vh"
module amfs_frame_sequencer (
  hclk,
  hresetn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hrdata,
  hreadyout,
  hresp,
  remote_sample_valid,
  remote_sample_data,
  mux_input_select,
  mux_advance,
  filter_start,
  reference_crossing_signal,
  engine_start,
  remote_capture,
  remote_wr_en,
  remote_wr_addr,
  remote_wr_data,
  differential_enable,
  preamp_enable,
  remote_sensor_enable,
  energy_equation_select
);
  input wire hclk;
  input wire hresetn;
  input wire hsel;
  input wire [31:0] haddr;
  input wire [1:0] htrans;
  input wire hwrite;
  input wire [2:0] hsize;
  input wire [31:0] hwdata;
  input wire hready;
  input wire [2:0] remote_sample_valid;
  input wire [23:0] remote_sample_data;
  output reg [31:0] hrdata;
  output reg hreadyout;
  output reg hresp;
  output reg [3:0] mux_input_select;
  output reg mux_advance;
  output reg filter_start;
  output reg reference_crossing_signal;
  output reg engine_start;
  output reg remote_capture;
  output reg remote_wr_en;
  output reg [3:0] remote_wr_addr;
  output reg [23:0] remote_wr_data;
  output reg [3:0] differential_enable;
  output reg preamp_enable;
  output reg [2:0] remote_sensor_enable;
  output reg [2:0] energy_equation_select;

  localparam ST_IDLE = 2'd0;
  localparam ST_LEAD = 2'd1;
  localparam ST_SLOT = 2'd2;

  reg [7:0] slot10_q, slot89_q, slot67_q, slot45_q, slot23_q, slot01_q;
  reg [7:0] eqchop_q, filt_q, rate_q, preamp_q, remote_q;
  reg [1:0] state_q;
  reg [3:0] slot_q;
  reg [4:0] lead_q;
  reg [8:0] frame_tick_q;
  reg [8:0] frame_len_q;
  reg chop_q;
  reg wr_pend_q;
  reg [15:0] wr_idx_q;
  reg [2:0] rmt_got_q;
  reg [1:0] rmt_ptr_q;
  reg restart;

  wire [3:0] slot_count = slot10_q[`AMFS_SLOT_COUNT_LSB +: 4];
  wire [1:0] fir_len = filt_q[`AMFS_FIR_LEN_LSB +: 2];
  wire [1:0] chop_ctl = eqchop_q[`AMFS_CHOP_LSB +: 2];
  wire adc_div = rate_q[`AMFS_ADC_DIV_BIT];
  wire pll_fast = rate_q[`AMFS_PLL_FAST_BIT];
  wire [4:0] lead_len = pll_fast ? 5'd1 : 5'd3;
  wire [4:0] slot_len;
  wire tick_rise;
  wire slot_done;

  // slot ticks from filter length, rate divider and pll speed
  function [4:0] slot_ticks;
    input pf;
    input [1:0] len;
    input div;
    reg [4:0] base;
    begin
      base = pf ? 5'd1 : 5'd3;
      slot_ticks = base * ({3'b000, len} + 5'd1) * ({4'b0000, div} + 5'd1);
    end
  endfunction

  // select field for slot n: two handles per byte, slot 10 alone
  function [3:0] slot_handle;
    input [3:0] n;
    input [7:0] r10, r89, r67, r45, r23, r01;
    reg [7:0] b;
    begin
      case (n[3:1])
        3'd0: b = r01;
        3'd1: b = r23;
        3'd2: b = r45;
        3'd3: b = r67;
        3'd4: b = r89;
        default: b = r10;
      endcase
      slot_handle = (n == 4'd10) ? r10[3:0] : (n[0] ? b[7:4] : b[3:0]);
    end
  endfunction

  assign slot_len = slot_ticks(pll_fast, fir_len, adc_div);

  amfs_tick_gen u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick_rise(tick_rise)
  );

  amfs_slot_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick_rise(tick_rise),
    .restart(restart),
    .slot_len(slot_len),
    .slot_done(slot_done)
  );

  // bus: zero wait, reads are of the register decoded in the address phase
  wire acc = hsel && hready && htrans[1];
  wire [15:0] acc_idx = haddr[17:2];

  function [7:0] reg_read;
    input [15:0] idx;
    begin
      case (idx)
        `AMFS_IDX_SLOT10: reg_read = slot10_q;
        `AMFS_IDX_SLOT89: reg_read = slot89_q;
        `AMFS_IDX_SLOT67: reg_read = slot67_q;
        `AMFS_IDX_SLOT45: reg_read = slot45_q;
        `AMFS_IDX_SLOT23: reg_read = slot23_q;
        `AMFS_IDX_SLOT01: reg_read = slot01_q;
        `AMFS_IDX_EQCHOP: reg_read = eqchop_q;
        `AMFS_IDX_FILT: reg_read = filt_q;
        `AMFS_IDX_RATE: reg_read = rate_q;
        `AMFS_IDX_PREAMP: reg_read = preamp_q;
        `AMFS_IDX_REMOTE: reg_read = remote_q;
        `AMFS_IDX_STATUS: reg_read = {state_q != ST_IDLE, 3'b000, slot_q};
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_idx_q <= 16'h0000;
    end else begin
      wr_pend_q <= acc && hwrite;
      if (acc) begin
        wr_idx_q <= acc_idx;
      end
      if (acc && !hwrite) begin
        hrdata <= {24'h000000, reg_read(acc_idx)};
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot10_q <= `AMFS_REG_RESET;
      slot89_q <= `AMFS_REG_RESET;
      slot67_q <= `AMFS_REG_RESET;
      slot45_q <= `AMFS_REG_RESET;
      slot23_q <= `AMFS_REG_RESET;
      slot01_q <= `AMFS_REG_RESET;
      eqchop_q <= `AMFS_REG_RESET;
      filt_q <= `AMFS_REG_RESET;
      rate_q <= `AMFS_REG_RESET;
      preamp_q <= `AMFS_REG_RESET;
      remote_q <= `AMFS_REG_RESET;
    end else if (wr_pend_q) begin
      case (wr_idx_q)
        `AMFS_IDX_SLOT10: slot10_q <= hwdata[7:0];
        `AMFS_IDX_SLOT89: slot89_q <= hwdata[7:0];
        `AMFS_IDX_SLOT67: slot67_q <= hwdata[7:0];
        `AMFS_IDX_SLOT45: slot45_q <= hwdata[7:0];
        `AMFS_IDX_SLOT23: slot23_q <= hwdata[7:0];
        `AMFS_IDX_SLOT01: slot01_q <= hwdata[7:0];
        `AMFS_IDX_EQCHOP: eqchop_q <= hwdata[7:0];
        `AMFS_IDX_FILT: filt_q <= hwdata[7:0];
        `AMFS_IDX_RATE: rate_q <= hwdata[7:0];
        `AMFS_IDX_PREAMP: preamp_q <= hwdata[7:0];
        `AMFS_IDX_REMOTE: remote_q <= hwdata[7:0];
        default: slot10_q <= slot10_q;
      endcase
    end
  end

  // static configuration out to the analog front end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      differential_enable <= 4'h0;
      preamp_enable <= 1'b0;
      remote_sensor_enable <= 3'b000;
      energy_equation_select <= 3'b000;
    end else begin
      differential_enable <= filt_q[7:4];
      preamp_enable <= preamp_q[5];
      remote_sensor_enable <= remote_q[`AMFS_RMT_LSB +: 3];
      energy_equation_select <= eqchop_q[7:5];
    end
  end

  // frame sequencing; a count above eleven is clipped to eleven
  wire [3:0] last_slot = ((slot_count > `AMFS_MAX_SLOTS) ? `AMFS_MAX_SLOTS : slot_count) - 4'd1;
  wire [8:0] frame_len_d = {4'h0, lead_len} + {4'h0, slot_len} * {5'h00, last_slot + 4'd1};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      slot_q <= 4'h0;
      lead_q <= 5'h00;
      chop_q <= 1'b0;
      mux_input_select <= 4'h0;
      mux_advance <= 1'b0;
      filter_start <= 1'b0;
      engine_start <= 1'b0;
      reference_crossing_signal <= 1'b0;
      restart <= 1'b1;
      frame_tick_q <= 9'h000;
      frame_len_q <= 9'h000;
    end else begin
      mux_advance <= 1'b0;
      filter_start <= 1'b0;
      engine_start <= 1'b0;
      restart <= 1'b0;
      if (tick_rise) begin
        frame_tick_q <= frame_tick_q + 9'h001;
      end
      // chop: 0 held low, 1 held high, 2 and 3 flip once per frame
      case (chop_ctl)
        2'd0: reference_crossing_signal <= 1'b0;
        2'd1: reference_crossing_signal <= 1'b1;
        default: reference_crossing_signal <= chop_q;
      endcase
      if (slot_count == 4'h0) begin
        state_q <= ST_IDLE;
        restart <= 1'b1;
        slot_q <= 4'h0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (tick_rise) begin
              state_q <= ST_LEAD;
              lead_q <= 5'h01;
              frame_tick_q <= 9'h001;
              frame_len_q <= frame_len_d;
              engine_start <= 1'b1;
              chop_q <= ~chop_q;
            end
          end
          ST_LEAD: begin
            // frame lead-in ticks before slot zero
            if (tick_rise) begin
              if (lead_q >= lead_len) begin
                state_q <= ST_SLOT;
                restart <= 1'b1;
                slot_q <= 4'h0;
                mux_input_select <= slot_handle(4'h0, slot10_q, slot89_q, slot67_q,
                  slot45_q, slot23_q, slot01_q);
                mux_advance <= 1'b1;
                filter_start <= 1'b1;
              end else begin
                lead_q <= lead_q + 5'h01;
              end
            end
          end
          ST_SLOT: begin
            if (slot_done) begin
              if (slot_q >= last_slot) begin
                state_q <= ST_LEAD;
                lead_q <= 5'h01;
                frame_tick_q <= 9'h001;
                frame_len_q <= frame_len_d;
                engine_start <= 1'b1;
                chop_q <= ~chop_q;
              end else begin
                slot_q <= slot_q + 4'h1;
                mux_input_select <= slot_handle(slot_q + 4'h1, slot10_q, slot89_q,
                  slot67_q, slot45_q, slot23_q, slot01_q);
                mux_advance <= 1'b1;
                filter_start <= 1'b1;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // remote samples: captured in second frame half, copied to engine memory
  wire second_half = (state_q != ST_IDLE) && ({frame_tick_q, 1'b0} >= {1'b0, frame_len_q});
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      remote_capture <= 1'b0;
      remote_wr_en <= 1'b0;
      remote_wr_addr <= 4'h0;
      remote_wr_data <= 24'h000000;
      rmt_got_q <= 3'b000;
      rmt_ptr_q <= 2'd0;
    end else begin
      remote_capture <= second_half && (remote_q[`AMFS_RMT_LSB +: 3] != 3'b000);
      remote_wr_en <= 1'b0;
      if (engine_start) begin
        rmt_got_q <= 3'b000;
        rmt_ptr_q <= 2'd0;
      end else if (second_half) begin
        // pairs polled in turn all through the half, so a late sensor is still taken
        rmt_ptr_q <= (rmt_ptr_q == 2'd2) ? 2'd0 : rmt_ptr_q + 2'd1;
        if (remote_q[`AMFS_RMT_LSB + rmt_ptr_q] && remote_sample_valid[rmt_ptr_q]
            && !rmt_got_q[rmt_ptr_q]) begin
          rmt_got_q[rmt_ptr_q] <= 1'b1;
          remote_wr_en <= 1'b1;
          remote_wr_addr <= {1'b0, rmt_ptr_q, 1'b0} + 4'h2; // current pair handle
          remote_wr_data <= remote_sample_data;
        end
      end
    end
  end
endmodule // amfs_frame_sequencer

/* amfs_frame_sequencer_asserts.sv */
module amfs_frame_sequencer_asserts (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire mux_advance,
  input wire filter_start,
  input wire engine_start,
  input wire remote_capture,
  input wire remote_wr_en,
  input wire [3:0] remote_wr_addr,
  input wire [2:0] remote_sensor_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 3050;
  int adv_gap_q;
  int eng_gap_q;
  logic adv_seen_q;
  logic eng_seen_q;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // first pulse after reset has no reference gap
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adv_gap_q <= 0;
      eng_gap_q <= 0;
      adv_seen_q <= 1'b0;
      eng_seen_q <= 1'b0;
    end else begin
      adv_gap_q <= mux_advance ? 1 : adv_gap_q + 1;
      eng_gap_q <= engine_start ? 1 : eng_gap_q + 1;
      adv_seen_q <= adv_seen_q | mux_advance;
      eng_seen_q <= eng_seen_q | engine_start;
    end
  end
  sequence s_read_req;
    hsel && htrans[1] && !hwrite && hreadyout;
  endsequence
  sequence s_pulse(logic sig);
    sig ##1 !sig;
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  chk_start_pair: assert property (mux_advance == filter_start)
    else $error("filter start not with mux advance");
  chk_adv_pulse: assert property (mux_advance |-> s_pulse(mux_advance))
    else $error("mux advance longer than one cycle");
  chk_engine_pulse: assert property (engine_start |-> s_pulse(engine_start))
    else $error("engine start longer than one cycle");
  chk_slot_tick: assert property (mux_advance && adv_seen_q |-> adv_gap_q % TICK == 0)
    else $error("slot start off the slow tick");
  chk_frame_tick: assert property (engine_start && eng_seen_q |-> eng_gap_q % TICK == 0)
    else $error("frame start off the slow tick");
  chk_capture_remote: assert property (remote_capture |->
    remote_sensor_enable != 3'h0 || $past(remote_sensor_enable) != 3'h0)
    else $error("capture with no remote pair enabled");
  chk_write_window: assert property (remote_wr_en |->
    remote_capture || $past(remote_capture))
    else $error("engine write outside capture window");
  chk_write_handle: assert property (remote_wr_en |->
    remote_wr_addr inside {4'h2, 4'h4, 4'h6})
    else $error("remote write to a non remote handle");
  chk_read_upper: assert property (s_read_req |=> hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule // amfs_frame_sequencer_asserts

/* amfs_remote_sensor_model.sv */
module amfs_remote_sensor_model #(
  parameter int LAG = 4,
  parameter logic [23:0] SAMPLE = 24'h3c5a96
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic remote_capture,
  input wire logic [2:0] remote_sensor_enable,
  output logic [2:0] remote_sample_valid,
  output logic [23:0] remote_sample_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int lag_q;
  logic on;
  assign on = remote_capture && lag_q == LAG;
  // sensors answer late in the window; stale data toggles, so it matches the sample only on every other cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lag_q <= 0;
      remote_sample_valid <= 3'h0;
      remote_sample_data <= ~SAMPLE;
    end else begin
      lag_q <= remote_capture ? (lag_q < LAG ? lag_q + 1 : lag_q) : 0;
      remote_sample_valid <= on ? remote_sensor_enable : 3'h0;
      remote_sample_data <= on ? SAMPLE : ~remote_sample_data;
    end
  end
endmodule // amfs_remote_sensor_model

/* test_adc_mux_frame_sequencer.sv */
module test_adc_mux_frame_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 3050;
  localparam logic [23:0] SMP = 24'h3c5a96;
  localparam logic [15:0] IDX [11] = '{16'h2100, 16'h2101, 16'h2102, 16'h2103, 16'h2104,
    16'h2105, 16'h2106, 16'h210c, 16'h2200, 16'h2704, 16'h2709};
  localparam logic [7:0] VAL [11] = '{8'h0a, 8'h21, 8'h43, 8'h65, 8'h87, 8'ha9, 8'hbc,
    8'h5a, 8'h20, 8'h20, 8'h28};
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, mux_advance, filter_start, reference_crossing_signal;
  logic engine_start, remote_capture, remote_wr_en, preamp_enable;
  logic [3:0] mux_input_select, remote_wr_addr, differential_enable;
  logic [2:0] remote_sample_valid, remote_sensor_enable, energy_equation_select;
  logic [23:0] remote_sample_data, remote_wr_data;
  int errors = 0, n_checks = 0;
  amfs_frame_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .remote_sample_valid(remote_sample_valid), .remote_sample_data(remote_sample_data),
    .mux_input_select(mux_input_select), .mux_advance(mux_advance),
    .filter_start(filter_start), .reference_crossing_signal(reference_crossing_signal),
    .engine_start(engine_start), .remote_capture(remote_capture),
    .remote_wr_en(remote_wr_en), .remote_wr_addr(remote_wr_addr),
    .remote_wr_data(remote_wr_data), .differential_enable(differential_enable),
    .preamp_enable(preamp_enable), .remote_sensor_enable(remote_sensor_enable),
    .energy_equation_select(energy_equation_select));
  amfs_remote_sensor_model #(.LAG(4), .SAMPLE(SMP)) u_sensor (.hclk(hclk),
    .hresetn(hresetn), .remote_capture(remote_capture),
    .remote_sensor_enable(remote_sensor_enable),
    .remote_sample_valid(remote_sample_valid), .remote_sample_data(remote_sample_data));
  initial begin
    forever #5 hclk = ~hclk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    haddr <= {14'h0, idx, 2'h0};
    hwrite <= wr;
    hsel <= 1'b1;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    check(what, rd, exp);
  endtask
  // count is parked at zero while rate, filter, preamp, remote and equation change; slot selects are written after the count
  task automatic cfg(input logic [7:0] rate, filt, pre, rmt, eq, cnt, s01, s23, s45);
    xfer(1'b1, 16'h2100, 32'h0);
    xfer(1'b1, 16'h2200, {24'h0, rate});
    xfer(1'b1, 16'h210c, {24'h0, filt});
    xfer(1'b1, 16'h2704, {24'h0, pre});
    xfer(1'b1, 16'h2709, {24'h0, rmt});
    xfer(1'b1, 16'h2106, {24'h0, eq});
    xfer(1'b1, 16'h2100, {24'h0, cnt});
    xfer(1'b1, 16'h2105, {24'h0, s01});
    xfer(1'b1, 16'h2104, {24'h0, s23});
    xfer(1'b1, 16'h2103, {24'h0, s45});
    xfer(1'b1, 16'h2102, 32'h0);
  endtask
  task automatic frame(input int slots, ticks, input logic [31:0] hx, input int wrs,
    input logic tog);
    int c, adv, pend, nwr;
    logic ref0;
    c = 0;
    adv = 0;
    pend = 0;
    nwr = 0;
    while (engine_start !== 1'b1 && c < 20 * TICK) begin
      @(negedge hclk);
      c++;
    end
    repeat (3) @(negedge hclk);
    ref0 = reference_crossing_signal;
    c = 3;
    do begin
      @(negedge hclk);
      c++;
      if (pend == 1) check("slot handle", mux_input_select, hx[4 * adv - 4 +: 4]);
      pend = (mux_advance === 1'b1) ? 3 : (pend > 0 ? pend - 1 : 0);
      adv += (mux_advance === 1'b1);
      if (remote_wr_en === 1'b1) begin
        check("remote addr", remote_wr_addr, 2 + 2 * nwr);
        check("remote data", remote_wr_data, SMP);
        nwr++;
      end
    end while (engine_start !== 1'b1 && c < 20 * TICK);
    check("frame length", c, ticks * TICK);
    check("slots per frame", adv, slots);
    check("remote writes", nwr, wrs);
    repeat (3) @(negedge hclk);
    check("crossing", reference_crossing_signal, ref0 ^ tog);
    @(posedge hclk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 11; i++) rchk("reset value", IDX[i], 32'h0);
    check("crossing off", reference_crossing_signal, 1'b0);
    for (int i = 0; i < 11; i++) xfer(1'b1, IDX[i], {24'hffffff, VAL[i]});
    for (int i = 0; i < 11; i++) rchk("readback", IDX[i], {24'h0, VAL[i]});
    xfer(1'b1, 16'h2300, 32'hff);
    rchk("unmapped", 16'h2300, 32'h0);
    check("differential", differential_enable, 4'h5);
    check("preamp", preamp_enable, 1'b1);
    check("remote enable", remote_sensor_enable, 3'h5);
    check("equation", energy_equation_select, 3'h5);
    $display("test registers done");
    cfg(8'h10, 8'hf2, 8'h00, 8'h00, 8'ha4, 8'h70, 8'h82, 8'h94, 8'ha6);
    check("differential", differential_enable, 4'hf);
    check("preamp", preamp_enable, 1'b0);
    check("remote enable", remote_sensor_enable, 3'h0);
    check("equation", energy_equation_select, 3'h5);
    frame(7, 15, 32'h00a69482, 0, 1'b0);
    check("crossing high", reference_crossing_signal, 1'b1);
    xfer(1'b0, 16'h2800, 32'h0);
    check("running", rd[7], 1'b1);
    xfer(1'b1, 16'h2100, 32'h0);
    // the sequencer sees the cleared count one cycle after the write lands
    @(posedge hclk);
    xfer(1'b0, 16'h2800, 32'h0);
    check("idle", rd[7], 1'b0);
    $display("test transformer frame done");
    cfg(8'h10, 8'h12, 8'h20, 8'h38, 8'ha8, 8'h60, 8'h10, 8'h81, 8'ha9);
    check("remote enable", remote_sensor_enable, 3'h7);
    check("differential", differential_enable, 4'h1);
    frame(6, 13, 32'h00a98110, 3, 1'b1);
    $display("test remote frame done");
    print_verdict;
  end
  initial begin
    repeat (100000) @(posedge hclk);
    errors++;
    print_verdict;
  end
endmodule // test_adc_mux_frame_sequencer
bind amfs_frame_sequencer amfs_frame_sequencer_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .mux_advance(mux_advance), .filter_start(filter_start),
  .engine_start(engine_start), .remote_capture(remote_capture), .remote_wr_en(remote_wr_en),
  .remote_wr_addr(remote_wr_addr), .remote_sensor_enable(remote_sensor_enable));
